// ---- rmcw_pkg.sv ----
// Package for the receive mode-command record writer.
// Assumes a 16-bit word-addressed shared RAM and one system clock.
package rmcw_pkg;

  // ------------------------------------------------------------
  // Record layout
  // ------------------------------------------------------------
  localparam logic [15:0] OFS_INFO = 16'h0000;
  localparam logic [15:0] OFS_TTAG = 16'h0001;
  localparam logic [15:0] OFS_DATA = 16'h0002;
  localparam logic [4:0] MC_FIRST_DATA = 5'h10;

  // ------------------------------------------------------------
  // Information word bit positions
  // ------------------------------------------------------------
  localparam int BIT_INVALID_WORD = 14;
  localparam int BIT_GAP_OR_BROADCAST_FLAG = 13;
  localparam int BIT_WORD_COUNT = 12;
  localparam int BIT_SYNC_TYPE = 11;
  localparam int BIT_MSG_FAULT = 10;
  localparam int BIT_BUSY = 9;
  localparam int BIT_ILLEGAL = 8;
  localparam int BIT_BUS_SEL = 5;

  // ------------------------------------------------------------
  // Undefined receive mode codes with data
  // ------------------------------------------------------------
  localparam logic [4:0] MC_UNDEF_A = 5'h10;
  localparam logic [4:0] MC_UNDEF_B = 5'h12;
  localparam logic [4:0] MC_UNDEF_C = 5'h13;

  // ------------------------------------------------------------
  // APB register map
  // ------------------------------------------------------------
  localparam logic [7:0] ADDR_CFG = 8'h00;
  localparam logic [7:0] ADDR_ILLEG = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h0C;
  localparam logic [7:0] ADDR_IRQ_EN = 8'h10;
  localparam logic [7:0] ADDR_IRQ_CLR = 8'h14;
  localparam logic [7:0] ADDR_LAST_INFO = 8'h18;
  localparam logic [7:0] ADDR_LAST_DATA = 8'h1C;

  localparam int CFG_UNDEF_INV = 0;
  localparam int CFG_GAP_MODE = 1;
  localparam int CFG_GLOBAL_BUSY = 2;

  localparam logic [2:0] CFG_RESET = 3'h0;
  localparam logic [31:0] ILLEG_RESET = 32'h0000_0000;
  localparam logic [1:0] IRQ_EN_RESET = 2'h0;

  // Interrupt status bits: message done (set as the record write starts), message fault
  localparam int IRQ_DONE = 0;
  localparam int IRQ_FAULT = 1;

  typedef enum logic [1:0] {
    RMCW_IDLE,
    RMCW_INFO,
    RMCW_TTAG,
    RMCW_DATA
  } rmcw_state_t;

endpackage

// ---- rmcw_writer.sv ----
// Receive mode-command record writer with APB control registers.
// Assumes the terminal's protocol logic gives one completion pulse per
// receive mode command with its flags, and RAM accepts one write per cycle.
//
// Decided for this implementation: the APB slave port and the register offsets.
`timescale 1ns/1ns

// What this block does
// R1: Codes 0 to 15 get only information and time-tag words.
// R2: Information word at data pointer, time tag at pointer plus one.
// R3: Codes 16 to 31 store their data word at pointer plus two.
// R4: Received mode data is kept in the record and offered to the terminal.
// R5: Undefined codes 16, 18, 19 answered in form when legal and allowed.
// R6: Codes 0 to 15 without data answered in form when legal and allowed.
// R7: Device writes every record word after the message completes.
// R8: Bit 14 flags Manchester or parity error in the data word.
// R9: Gap mode: bit 13 flags activity after or gap before data.
// R10: Broadcast mode: bit 13 flags a broadcast message.
// R11: Bit 12 flags a missing or extra data word.
// R12: Bit 11 flags command sync on the data word.
// R13: Bit 10 summarises bits 11, 12 and 14, and bit 13 in gap mode only.
// R14: Bit 9 flags a busy reply, global or per command.
// R15: Bit 8 mirrors the illegalization bit of the command.
// R16: Host loads nonzero illegalization bits only for illegal-command detection.
// R17: Bit 5 is zero for bus A, one for bus B.
// R18: Bits 4 to 0 hold the mode code.
// R19: Bits 15, 7 and 6 are written as zero.
module rmcw_writer (
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  input wire logic i_msg_done,
  input wire logic [4:0] i_mode_code,
  input wire logic [15:0] i_data_ptr,
  input wire logic [15:0] i_time_tag,
  input wire logic [15:0] i_mode_data,
  input wire logic i_has_data_word,
  input wire logic i_invalid_word,
  input wire logic i_gap_event,
  input wire logic i_broadcast,
  input wire logic i_word_count_bad,
  input wire logic i_sync_bad,
  input wire logic i_per_command_busy,
  input wire logic i_bus_b,
  output logic [15:0] o_ram_addr,
  output logic [15:0] o_ram_wdata,
  output logic o_ram_we,
  output logic o_busy,
  output logic o_respond_in_form,
  output logic o_busy_reply,
  output logic o_apply_data,
  output logic [15:0] o_applied_data,
  output logic o_irq
);

  // ------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------
  logic [2:0] cfg_ff;
  logic [31:0] illeg_ff;
  logic [1:0] irq_stat_ff;
  logic [1:0] irq_en_ff;
  logic [15:0] info_ff;
  logic [15:0] ttag_ff;
  logic [15:0] data_ff;
  logic [15:0] ptr_ff;
  logic with_data_ff;
  logic apply_ff;
  logic [15:0] applied_ff;
  rmcw_pkg::rmcw_state_t state_ff;
  rmcw_pkg::rmcw_state_t nxt_state;

  // ------------------------------------------------------------
  // APB decode
  // ------------------------------------------------------------
  wire logic acc = i_psel && i_penable;
  wire logic wr = acc && i_pwrite;
  wire logic hit_cfg = i_paddr == rmcw_pkg::ADDR_CFG;
  wire logic hit_illeg = i_paddr == rmcw_pkg::ADDR_ILLEG;
  wire logic hit_stat = i_paddr == rmcw_pkg::ADDR_STATUS;
  wire logic hit_istat = i_paddr == rmcw_pkg::ADDR_IRQ_STAT;
  wire logic hit_ien = i_paddr == rmcw_pkg::ADDR_IRQ_EN;
  wire logic hit_iclr = i_paddr == rmcw_pkg::ADDR_IRQ_CLR;
  wire logic hit_linfo = i_paddr == rmcw_pkg::ADDR_LAST_INFO;
  wire logic hit_ldata = i_paddr == rmcw_pkg::ADDR_LAST_DATA;
  wire logic hit_any = hit_cfg | hit_illeg | hit_stat | hit_istat | hit_ien | hit_iclr
                       | hit_linfo | hit_ldata;

  assign o_pready = 1'b1;
  assign o_pslverr = acc && !hit_any;

  // ------------------------------------------------------------
  // Information word assembly
  // ------------------------------------------------------------
  wire logic has_data = i_mode_code >= rmcw_pkg::MC_FIRST_DATA; // [R1] [R3]
  wire logic illegal = illeg_ff[i_mode_code]; // [R15]
  wire logic undef_data = i_mode_code == rmcw_pkg::MC_UNDEF_A
                          || i_mode_code == rmcw_pkg::MC_UNDEF_B
                          || i_mode_code == rmcw_pkg::MC_UNDEF_C;
  wire logic undefined = undef_data || !has_data;
  wire logic allowed = !illegal && !cfg_ff[rmcw_pkg::CFG_UNDEF_INV];
  wire logic busy_reply = cfg_ff[rmcw_pkg::CFG_GLOBAL_BUSY] || i_per_command_busy; // [R14]
  wire logic gap_bit = cfg_ff[rmcw_pkg::CFG_GAP_MODE] ? i_gap_event // [R9]
                                                       : i_broadcast; // [R10]
  wire logic fault = i_invalid_word || gap_bit && cfg_ff[rmcw_pkg::CFG_GAP_MODE]
                     || i_word_count_bad || i_sync_bad;
  logic [15:0] info_word;

  always_comb begin
    info_word = 16'h0000; // [R19]
    info_word[rmcw_pkg::BIT_INVALID_WORD] = i_invalid_word; // [R8]
    info_word[rmcw_pkg::BIT_GAP_OR_BROADCAST_FLAG] = gap_bit;
    info_word[rmcw_pkg::BIT_WORD_COUNT] = i_word_count_bad; // [R11]
    info_word[rmcw_pkg::BIT_SYNC_TYPE] = i_sync_bad; // [R12]
    info_word[rmcw_pkg::BIT_MSG_FAULT] = fault; // [R13]
    info_word[rmcw_pkg::BIT_BUSY] = busy_reply;
    info_word[rmcw_pkg::BIT_ILLEGAL] = illegal;
    info_word[rmcw_pkg::BIT_BUS_SEL] = i_bus_b; // [R17]
    info_word[4:0] = i_mode_code; // [R18]
  end

  // In-form answer for undefined codes, busy reply for every code
  assign o_respond_in_form = !undefined || allowed; // [R5] [R6]
  assign o_busy_reply = busy_reply;

  // ------------------------------------------------------------
  // Record write sequencer
  // ------------------------------------------------------------
  wire logic start = i_msg_done && state_ff == rmcw_pkg::RMCW_IDLE; // [R7]

  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      rmcw_pkg::RMCW_IDLE: if (start) nxt_state = rmcw_pkg::RMCW_INFO;
      rmcw_pkg::RMCW_INFO: nxt_state = rmcw_pkg::RMCW_TTAG;
      rmcw_pkg::RMCW_TTAG: nxt_state = with_data_ff ? rmcw_pkg::RMCW_DATA
                                                    : rmcw_pkg::RMCW_IDLE;
      rmcw_pkg::RMCW_DATA: nxt_state = rmcw_pkg::RMCW_IDLE;
    endcase
  end

  assign o_busy = state_ff != rmcw_pkg::RMCW_IDLE;
  assign o_ram_we = o_busy;
  assign o_ram_addr = state_ff == rmcw_pkg::RMCW_INFO ? ptr_ff + rmcw_pkg::OFS_INFO // [R2]
                    : state_ff == rmcw_pkg::RMCW_TTAG ? ptr_ff + rmcw_pkg::OFS_TTAG
                    : ptr_ff + rmcw_pkg::OFS_DATA; // [R3]
  assign o_ram_wdata = state_ff == rmcw_pkg::RMCW_INFO ? info_ff
                     : state_ff == rmcw_pkg::RMCW_TTAG ? ttag_ff : data_ff;
  assign o_apply_data = apply_ff;
  assign o_applied_data = applied_ff;

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      state_ff <= rmcw_pkg::RMCW_IDLE;
      info_ff <= 16'h0000;
      ttag_ff <= 16'h0000;
      data_ff <= 16'h0000;
      ptr_ff <= 16'h0000;
      with_data_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      if (start) begin
        info_ff <= info_word;
        ttag_ff <= i_time_tag;
        data_ff <= i_mode_data; // [R4]
        ptr_ff <= i_data_ptr;
        with_data_ff <= has_data; // [R1]
      end
    end
  end

  // Mode data handed to the terminal when a clean data word of a legal command arrived
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      apply_ff <= 1'b0;
      applied_ff <= 16'h0000;
    end else begin
      apply_ff <= start && has_data && i_has_data_word && !fault && !illegal; // [R4]
      if (start && has_data) begin
        applied_ff <= i_mode_data;
      end
    end
  end

  // ------------------------------------------------------------
  // Control registers and interrupts
  // ------------------------------------------------------------
  wire logic [1:0] irq_set = {start && fault, start};
  wire logic [1:0] irq_clr = (wr && hit_iclr) ? i_pwdata[1:0] : 2'h0;

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      cfg_ff <= rmcw_pkg::CFG_RESET;
      illeg_ff <= rmcw_pkg::ILLEG_RESET;
      irq_en_ff <= rmcw_pkg::IRQ_EN_RESET;
      irq_stat_ff <= 2'h0;
    end else begin
      if (wr && hit_cfg) cfg_ff <= i_pwdata[2:0];
      if (wr && hit_illeg) illeg_ff <= i_pwdata; // [R16]
      if (wr && hit_ien) irq_en_ff <= i_pwdata[1:0];
      irq_stat_ff <= (irq_stat_ff & ~irq_clr) | irq_set;
    end
  end

  assign o_irq = |(irq_stat_ff & irq_en_ff);

  wire logic [31:0] rd_mux = hit_cfg ? {29'h0, cfg_ff}
                           : hit_illeg ? illeg_ff
                           : hit_stat ? {31'h0, o_busy}
                           : hit_istat ? {30'h0, irq_stat_ff}
                           : hit_ien ? {30'h0, irq_en_ff}
                           : hit_linfo ? {16'h0, info_ff}
                           : hit_ldata ? {16'h0, data_ff} : 32'h0;
  assign o_prdata = (acc && !i_pwrite) ? rd_mux : 32'h0;

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  property p_no_data_word;
    @(posedge i_sys_clk) disable iff (i_rst)
      (i_msg_done && !o_busy && i_mode_code < 5'h10) |-> ##2 o_ram_we ##1 !o_ram_we;
  endproperty
  a_no_data_word: assert property (p_no_data_word) else $error("extra word written"); // [R1]

  sequence s_info_ttag;
    o_ram_we && o_ram_addr == $past(i_data_ptr) ##1 o_ram_we;
  endsequence
  property p_layout;
    @(posedge i_sys_clk) disable iff (i_rst)
      (i_msg_done && !o_busy) |-> ##1 s_info_ttag;
  endproperty
  a_layout: assert property (p_layout) else $error("record layout wrong"); // [R2]

  property p_data_addr;
    @(posedge i_sys_clk) disable iff (i_rst)
      (i_msg_done && !o_busy && i_mode_code >= 5'h10) |->
        ##3 o_ram_we && o_ram_addr == $past(i_data_ptr, 3) + 16'h0002
            && o_ram_wdata == $past(i_mode_data, 3);
  endproperty
  a_data_addr: assert property (p_data_addr) else $error("data word misplaced"); // [R3]

  property p_summary;
    @(posedge i_sys_clk) disable iff (i_rst)
      (state_ff == rmcw_pkg::RMCW_INFO && |o_ram_wdata[14:11]
       && !(o_ram_wdata[13] && !cfg_ff[rmcw_pkg::CFG_GAP_MODE])) |-> o_ram_wdata[10];
  endproperty
  a_summary: assert property (p_summary) else $error("summary bit missing"); // [R13]

  property p_zero_bits;
    @(posedge i_sys_clk) disable iff (i_rst)
      state_ff == rmcw_pkg::RMCW_INFO |-> o_ram_wdata[15] == 1'b0 && o_ram_wdata[7:6] == 2'h0;
  endproperty
  a_zero_bits: assert property (p_zero_bits) else $error("unused bits set"); // [R19]

  property p_mode_field;
    @(posedge i_sys_clk) disable iff (i_rst)
      (i_msg_done && !o_busy) |-> ##1 o_ram_wdata[4:0] == $past(i_mode_code)
                                       && o_ram_wdata[5] == $past(i_bus_b);
  endproperty
  a_mode_field: assert property (p_mode_field) else $error("mode or bus field wrong"); // [R18]

  property p_illegal;
    @(posedge i_sys_clk) disable iff (i_rst)
      (i_msg_done && !o_busy) |-> ##1 o_ram_wdata[8] == $past(illeg_ff[i_mode_code]);
  endproperty
  a_illegal: assert property (p_illegal) else $error("illegal flag wrong"); // [R15]

  property p_in_form;
    @(posedge i_sys_clk) disable iff (i_rst)
      (i_mode_code < 5'h10 && illeg_ff[i_mode_code]) |-> !o_respond_in_form;
  endproperty
  a_in_form: assert property (p_in_form) else $error("illegal code answered"); // [R6]

  property p_bcast;
    @(posedge i_sys_clk) disable iff (i_rst)
      (i_msg_done && !o_busy && !cfg_ff[rmcw_pkg::CFG_GAP_MODE]) |->
        ##1 o_ram_wdata[13] == $past(i_broadcast);
  endproperty
  a_bcast: assert property (p_bcast) else $error("broadcast flag wrong"); // [R10]

  // ------------------------------------------------------------
  // Flag, answer and interrupt checks
  // ------------------------------------------------------------
  sequence s_rec_start;
    i_msg_done && !o_busy;
  endsequence

  property p_invalid_word;
    @(posedge i_sys_clk) disable iff (i_rst)
      s_rec_start |-> ##1 o_ram_wdata[rmcw_pkg::BIT_INVALID_WORD] == $past(i_invalid_word);
  endproperty
  a_invalid_word: assert property (p_invalid_word) else $error("invalid flag wrong"); // [R8]

  property p_gap_flag;
    @(posedge i_sys_clk) disable iff (i_rst)
      (s_rec_start ##0 cfg_ff[rmcw_pkg::CFG_GAP_MODE])
        |-> ##1 o_ram_wdata[rmcw_pkg::BIT_GAP_OR_BROADCAST_FLAG] == $past(i_gap_event);
  endproperty
  a_gap_flag: assert property (p_gap_flag) else $error("gap flag wrong"); // [R9]

  property p_gap_summary;
    @(posedge i_sys_clk) disable iff (i_rst)
      (s_rec_start ##0 (cfg_ff[rmcw_pkg::CFG_GAP_MODE] && i_gap_event))
        |-> ##1 o_ram_wdata[rmcw_pkg::BIT_MSG_FAULT];
  endproperty
  a_gap_summary: assert property (p_gap_summary) else $error("gap not summarised"); // [R13]

  property p_word_count;
    @(posedge i_sys_clk) disable iff (i_rst)
      s_rec_start |-> ##1 o_ram_wdata[rmcw_pkg::BIT_WORD_COUNT] == $past(i_word_count_bad);
  endproperty
  a_word_count: assert property (p_word_count) else $error("word count flag wrong"); // [R11]

  property p_sync_type;
    @(posedge i_sys_clk) disable iff (i_rst)
      s_rec_start |-> ##1 o_ram_wdata[rmcw_pkg::BIT_SYNC_TYPE] == $past(i_sync_bad);
  endproperty
  a_sync_type: assert property (p_sync_type) else $error("sync flag wrong"); // [R12]

  property p_busy_bit;
    @(posedge i_sys_clk) disable iff (i_rst)
      s_rec_start |-> ##1 o_ram_wdata[rmcw_pkg::BIT_BUSY] ==
        $past(i_per_command_busy || cfg_ff[rmcw_pkg::CFG_GLOBAL_BUSY]);
  endproperty
  a_busy_bit: assert property (p_busy_bit) else $error("busy bit wrong"); // [R14]

  property p_busy_reply;
    @(posedge i_sys_clk) disable iff (i_rst)
      (i_per_command_busy || cfg_ff[rmcw_pkg::CFG_GLOBAL_BUSY]) |-> o_busy_reply;
  endproperty
  a_busy_reply: assert property (p_busy_reply) else $error("busy reply missing"); // [R14]

  property p_undef_form;
    @(posedge i_sys_clk) disable iff (i_rst)
      ((i_mode_code == rmcw_pkg::MC_UNDEF_A || i_mode_code == rmcw_pkg::MC_UNDEF_B
        || i_mode_code == rmcw_pkg::MC_UNDEF_C) && !illeg_ff[i_mode_code]
        && !cfg_ff[rmcw_pkg::CFG_UNDEF_INV]) |-> o_respond_in_form;
  endproperty
  a_undef_form: assert property (p_undef_form) else $error("undefined refused"); // [R5]

  property p_plain_form;
    @(posedge i_sys_clk) disable iff (i_rst)
      (i_mode_code < rmcw_pkg::MC_FIRST_DATA && !illeg_ff[i_mode_code]
       && !cfg_ff[rmcw_pkg::CFG_UNDEF_INV]) |-> o_respond_in_form;
  endproperty
  a_plain_form: assert property (p_plain_form) else $error("plain code refused"); // [R6]

  property p_apply_src;
    @(posedge i_sys_clk) disable iff (i_rst)
      o_apply_data |-> $past(i_msg_done && !o_busy && i_has_data_word)
                       && o_applied_data == $past(i_mode_data);
  endproperty
  a_apply_src: assert property (p_apply_src) else $error("applied data wrong"); // [R4]

  property p_apply_clean;
    @(posedge i_sys_clk) disable iff (i_rst)
      (s_rec_start ##0 (has_data && i_has_data_word && !fault && !illegal))
        |-> ##1 o_apply_data;
  endproperty
  a_apply_clean: assert property (p_apply_clean) else $error("clean data not applied"); // [R4]

  property p_done_irq;
    @(posedge i_sys_clk) disable iff (i_rst)
      s_rec_start |-> ##1 irq_stat_ff[rmcw_pkg::IRQ_DONE];
  endproperty
  a_done_irq: assert property (p_done_irq) else $error("done status missing"); // [R7]

  property p_fault_irq;
    @(posedge i_sys_clk) disable iff (i_rst)
      (s_rec_start ##0 fault) |-> ##1 irq_stat_ff[rmcw_pkg::IRQ_FAULT];
  endproperty
  a_fault_irq: assert property (p_fault_irq) else $error("fault status missing"); // [R13]

  property p_data_len;
    @(posedge i_sys_clk) disable iff (i_rst)
      (s_rec_start ##0 i_mode_code >= rmcw_pkg::MC_FIRST_DATA)
        |-> ##1 o_ram_we [*3] ##1 !o_ram_we;
  endproperty
  a_data_len: assert property (p_data_len) else $error("data record length wrong"); // [R3]

endmodule

// ---- rmcw_bc_model.sv ----
// Bus controller stand-in that hands completed receive mode commands to the writer.
// Assumes the writer samples all command fields on the one-cycle done pulse.
`timescale 1ns/1ns
module rmcw_bc_model (
  input wire logic i_sys_clk,
  input wire logic i_rif,
  input wire logic i_brep,
  input wire logic i_apply,
  input wire logic [15:0] i_applied,
  input wire logic i_busy,
  output logic o_done,
  output logic [4:0] o_mc,
  output logic [15:0] o_ptr,
  output logic [15:0] o_tag,
  output logic [15:0] o_dat,
  output logic o_hasd,
  output logic [6:0] o_flags
);
  logic rif_seen, brep_seen, apply_seen;
  logic [15:0] applied_seen;

  initial begin
    o_done = 1'b0;
    {o_mc, o_ptr, o_tag, o_dat, o_hasd, o_flags} = '0;
  end

  task automatic issue(input logic [4:0] mc, input logic [15:0] ptr, input logic [15:0] tag,
                       input logic [15:0] dat, input logic hasd, input logic [6:0] f);
    @(posedge i_sys_clk);
    o_done <= 1'b1;
    {o_mc, o_ptr, o_tag, o_dat, o_hasd, o_flags} <= {mc, ptr, tag, dat, hasd, f};
    @(posedge i_sys_clk);
    rif_seen = i_rif;
    brep_seen = i_brep;
    o_done <= 1'b0;
    // Fields no longer valid: show their inverse
    {o_mc, o_ptr, o_tag, o_dat, o_hasd, o_flags} <= ~{mc, ptr, tag, dat, hasd, f};
    @(posedge i_sys_clk);
    apply_seen = i_apply;
    applied_seen = i_applied;
    while (i_busy === 1'b1) begin
      @(posedge i_sys_clk);
    end
  endtask
endmodule

// ---- tb_rt_mode_command_record_writer.sv ----
// Self-checking bench: APB master tasks plus a table of receive mode commands.
// Assumes the writer package constants and a zero-wait APB slave.
`timescale 1ns/1ns
module tb_rt_mode_command_record_writer;
  logic i_sys_clk = 1'b0;
  logic i_rst = 1'b1;
  logic i_psel = 1'b0, i_penable = 1'b0, i_pwrite = 1'b0;
  logic [7:0] i_paddr = 8'h00;
  logic [31:0] i_pwdata = 32'h0;
  logic [31:0] o_prdata, rd;
  logic o_pready, o_pslverr, err, done, hasd, we, busy, rif, brep, apply, irq, ap, un;
  logic [4:0] mc;
  logic [6:0] fl;
  logic [1:0] en;
  logic [15:0] ptr, ttag, mdat, waddr, wdata, applied, p, xi;
  logic [15:0] qa [$];
  logic [15:0] qd [$];
  int bad_count = 0, checked = 0, cycles = 0;
  logic [4:0] t_mc [9] = '{5'h05, 5'h0F, 5'h10, 5'h12, 5'h13, 5'h11, 5'h1F, 5'h14, 5'h00};
  logic [2:0] t_cfg [9] = '{3'h0, 3'h1, 3'h0, 3'h0, 3'h2, 3'h1, 3'h4, 3'h0, 3'h0};
  logic [6:0] t_f [9] = '{7'h00, 7'h01, 7'h40, 7'h10, 7'h20, 7'h08, 7'h05, 7'h02, 7'h00};
  logic [31:0] t_il [9] = '{32'h0, 32'h0, 32'h10000, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h1};

  always #50 i_sys_clk = ~i_sys_clk;

  rmcw_writer DUT (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_psel(i_psel), .i_penable(i_penable),
    .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(o_prdata),
    .o_pready(o_pready), .o_pslverr(o_pslverr), .i_msg_done(done), .i_mode_code(mc),
    .i_data_ptr(ptr), .i_time_tag(ttag), .i_mode_data(mdat), .i_has_data_word(hasd),
    .i_invalid_word(fl[6]), .i_gap_event(fl[5]), .i_broadcast(fl[4]),
    .i_word_count_bad(fl[3]), .i_sync_bad(fl[2]), .i_per_command_busy(fl[1]),
    .i_bus_b(fl[0]), .o_ram_addr(waddr), .o_ram_wdata(wdata), .o_ram_we(we), .o_busy(busy),
    .o_respond_in_form(rif), .o_busy_reply(brep), .o_apply_data(apply),
    .o_applied_data(applied), .o_irq(irq));

  rmcw_bc_model u_bc (.i_sys_clk(i_sys_clk), .i_rif(rif), .i_brep(brep), .i_apply(apply),
    .i_applied(applied), .i_busy(busy), .o_done(done), .o_mc(mc), .o_ptr(ptr), .o_tag(ttag),
    .o_dat(mdat), .o_hasd(hasd), .o_flags(fl));

  // ------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge i_sys_clk);
    {i_psel, i_penable, i_pwrite, i_paddr, i_pwdata} <= {1'b1, 1'b0, w, a, d};
    @(posedge i_sys_clk);
    i_penable <= 1'b1;
    do begin
      @(posedge i_sys_clk);
    end while (o_pready !== 1'b1);
    rd = o_prdata;
    err = o_pslverr;
    {i_psel, i_penable} <= 2'h0;
  endtask

  task automatic print_verdict();
    $display("Comparisons %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  function automatic logic [15:0] info(input logic [4:0] c, input logic [2:0] cfg,
                                       input logic [31:0] il, input logic [6:0] f);
    logic flt;
    flt = f[6] | f[3] | f[2] | (cfg[1] & f[5]);
    info = {1'b0, f[6], cfg[1] ? f[5] : f[4], f[3], f[2], flt, cfg[2] | f[1], il[c], 2'h0,
            f[0], c};
  endfunction

  always @(posedge i_sys_clk) begin
    cycles++;
    if (we === 1'b1) begin
      qa.push_back(waddr);
      qd.push_back(wdata);
    end
    if (cycles == 5000) begin
      bad_count++;
      print_verdict();
    end
  end

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    repeat (20) @(posedge i_sys_clk);
    i_rst <= 1'b0;
    for (int a = 0; a < 8; a++) begin
      apb(1'b0, 8'(a * 4), 32'h0);
      check("reset value", rd, 32'h0);
    end
    apb(1'b1, 8'h20, 32'hFFFFFFFF);
    check("unmapped write error", err, 1'b1);
    apb(1'b0, 8'h20, 32'h0);
    check("unmapped read", {err, rd[30:0]}, 32'h80000000);
    for (int i = 0; i < 9; i++) begin
      en = i[0] ? 2'h0 : 2'h3;
      p = 16'h1500 + {i[11:0], 4'h0};
      xi = info(t_mc[i], t_cfg[i], t_il[i], t_f[i]);
      apb(1'b1, rmcw_pkg::ADDR_CFG, {29'h0, t_cfg[i]});
      apb(1'b1, rmcw_pkg::ADDR_ILLEG, t_il[i]);
      apb(1'b1, rmcw_pkg::ADDR_IRQ_EN, {30'h0, en});
      u_bc.issue(t_mc[i], p, {12'hA00, i[3:0]}, {12'h5A0, i[3:0]}, t_mc[i][4] & ~t_f[i][3],
                 t_f[i]);
      un = t_mc[i] < 5'h10 || t_mc[i] == 5'h10 || t_mc[i] == 5'h12 || t_mc[i] == 5'h13;
      check("in form", u_bc.rif_seen, !(un & (t_il[i][t_mc[i]] | t_cfg[i][0])));
      check("busy reply", u_bc.brep_seen, t_cfg[i][2] | t_f[i][1]);
      ap = t_mc[i][4] & ~t_f[i][3] & ~xi[10] & ~t_il[i][t_mc[i]];
      check("apply data", u_bc.apply_seen, ap);
      if (ap)
        check("applied data", u_bc.applied_seen, {12'h5A0, i[3:0]});
      check("record words", qa.size(), t_mc[i][4] ? 3 : 2);
      check("info addr", qa[0], p);
      check("info", qd[0], xi);
      check("tag addr", qa[1], p + 16'h1);
      check("tag word", qd[1], {12'hA00, i[3:0]});
      if (t_mc[i][4])
        check("data addr", qa[2], p + 16'h2);
      if (ap)
        check("data word", qd[2], {12'h5A0, i[3:0]});
      qa.delete();
      qd.delete();
      apb(1'b0, rmcw_pkg::ADDR_LAST_INFO, 32'h0);
      check("last info", rd, {16'h0, xi});
      apb(1'b0, rmcw_pkg::ADDR_IRQ_STAT, 32'h0);
      check("irq status", rd, {30'h0, xi[10], 1'b1});
      check("irq level", irq, en != 2'h0);
      apb(1'b1, rmcw_pkg::ADDR_IRQ_CLR, 32'h3);
      @(posedge i_sys_clk);
      check("irq cleared", irq, 1'b0);
    end
    print_verdict();
  end
endmodule
